// ### logic/dfs_pkg.sv
// Purpose: shared constants and types for the digital i/o function select block
// Assumes: parameter port addresses are the fieldbus parameter addresses
// Notes: codes are the function codes of the selectors, unsigned 16 bit
package dfs_pkg;

  // ----------------------------------------------------------------
  // parameter addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] DFS_IN3_SEL_OFS = 16'h0708;
  localparam logic [15:0] DFS_OUT0_SEL_OFS = 16'h0712;
  localparam logic [15:0] DFS_OUT1_SEL_OFS = 16'h0714;

  // ----------------------------------------------------------------
  // input function codes
  // ----------------------------------------------------------------
  localparam logic [15:0] DFS_IN_FREE = 16'h0001;
  localparam logic [15:0] DFS_IN_FAULT_RESET = 16'h0002;
  localparam logic [15:0] DFS_IN_ENABLE = 16'h0003;
  localparam logic [15:0] DFS_IN_HALT = 16'h0004;
  localparam logic [15:0] DFS_IN_START_PP = 16'h0005;
  localparam logic [15:0] DFS_IN_CUR_LIMIT = 16'h0006;
  localparam logic [15:0] DFS_IN_ZERO_CLAMP = 16'h0007;
  localparam logic [15:0] DFS_IN_VEL_LIMIT = 16'h0008;
  localparam logic [15:0] DFS_IN_REF_SW = 16'h0015;
  localparam logic [15:0] DFS_IN_LIM_POS = 16'h0016;
  localparam logic [15:0] DFS_IN_LIM_NEG = 16'h0017;
  localparam logic [15:0] DFS_IN_PARSET = 16'h0018;
  localparam logic [15:0] DFS_IN_VEL_INT_OFF = 16'h001C;
  localparam logic [15:0] DFS_IN_RELMOVE_START = 16'h001E;
  localparam logic [15:0] DFS_IN_RELMOVE_ARM = 16'h001F;
  localparam logic [15:0] DFS_IN_BRAKE_REL = 16'h0028;

  // ----------------------------------------------------------------
  // output function codes
  // ----------------------------------------------------------------
  localparam logic [15:0] DFS_OUT_FREE = 16'h0001;
  localparam logic [15:0] DFS_OUT_NO_FAULT = 16'h0002;
  localparam logic [15:0] DFS_OUT_ACTIVE = 16'h0003;
  localparam logic [15:0] DFS_OUT_RELMOVE_DONE = 16'h0004;
  localparam logic [15:0] DFS_OUT_IN_POS_WIN = 16'h0005;
  localparam logic [15:0] DFS_OUT_IN_VEL_WIN = 16'h0006;
  localparam logic [15:0] DFS_OUT_VEL_BELOW = 16'h0007;
  localparam logic [15:0] DFS_OUT_CUR_BELOW = 16'h0008;
  localparam logic [15:0] DFS_OUT_HALT_ACK = 16'h0009;
  localparam logic [15:0] DFS_OUT_STANDSTILL = 16'h000D;
  localparam logic [15:0] DFS_OUT_SEL_ERROR = 16'h000E;
  localparam logic [15:0] DFS_OUT_REF_OK = 16'h000F;
  localparam logic [15:0] DFS_OUT_SEL_WARN = 16'h0010;
  localparam logic [15:0] DFS_OUT_POS_REG1 = 16'h0012;
  localparam logic [15:0] DFS_OUT_POS_REG2 = 16'h0013;
  localparam logic [15:0] DFS_OUT_POS_REG3 = 16'h0014;
  localparam logic [15:0] DFS_OUT_POS_REG4 = 16'h0015;
  localparam logic [15:0] DFS_OUT_MOVES_POS = 16'h0016;
  localparam logic [15:0] DFS_OUT_MOVES_NEG = 16'h0017;

  // ----------------------------------------------------------------
  // factory settings
  // ----------------------------------------------------------------
  localparam logic [15:0] DFS_IN3_SEL_RST = DFS_IN_FREE;
  localparam logic [15:0] DFS_OUT0_SEL_RST = DFS_OUT_NO_FAULT;
  localparam logic [15:0] DFS_OUT1_SEL_RST = DFS_OUT_ACTIVE;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    dfs_st_not_ready,
    dfs_st_switch_on_disabled,
    dfs_st_ready_to_switch_on,
    dfs_st_switched_on,
    dfs_st_operation_enabled,
    dfs_st_quick_stop_active,
    dfs_st_fault_reaction,
    dfs_st_fault
  } dfs_opstate_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dfs_param_req_s;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } dfs_param_rsp_s;

  typedef struct packed {
    logic free_level;
    logic fault_reset;
    logic enable;
    logic halt;
    logic start_pp;
    logic cur_limit;
    logic zero_clamp;
    logic vel_limit;
    logic ref_switch;
    logic positive_limit_switch;
    logic negative_limit_switch;
    logic parset_sel;
    logic vel_int_off;
    logic relmove_start;
    logic relmove_arm;
    logic brake_release;
  } dfs_di_func_s;

  typedef struct packed {
    logic relmove_done;
    logic in_pos_win;
    logic in_vel_win;
    logic vel_below;
    logic cur_below;
    logic halt_ack;
    logic standstill;
    logic sel_error;
    logic ref_ok;
    logic sel_warning;
    logic [3:0] pos_reg;
    logic moves_pos;
    logic moves_neg;
  } dfs_status_s;

  function automatic logic dfs_in_code_ok(input logic [15:0] code);
    unique case (code)
      DFS_IN_FREE, DFS_IN_FAULT_RESET, DFS_IN_ENABLE, DFS_IN_HALT,
      DFS_IN_START_PP, DFS_IN_CUR_LIMIT, DFS_IN_ZERO_CLAMP, DFS_IN_VEL_LIMIT,
      DFS_IN_REF_SW, DFS_IN_LIM_POS, DFS_IN_LIM_NEG, DFS_IN_PARSET,
      DFS_IN_VEL_INT_OFF, DFS_IN_RELMOVE_START, DFS_IN_RELMOVE_ARM,
      DFS_IN_BRAKE_REL: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : dfs_in_code_ok

  function automatic logic dfs_out_code_ok(input logic [15:0] code);
    unique case (code)
      DFS_OUT_FREE, DFS_OUT_NO_FAULT, DFS_OUT_ACTIVE, DFS_OUT_RELMOVE_DONE,
      DFS_OUT_IN_POS_WIN, DFS_OUT_IN_VEL_WIN, DFS_OUT_VEL_BELOW,
      DFS_OUT_CUR_BELOW, DFS_OUT_HALT_ACK, DFS_OUT_STANDSTILL,
      DFS_OUT_SEL_ERROR, DFS_OUT_REF_OK, DFS_OUT_SEL_WARN, DFS_OUT_POS_REG1,
      DFS_OUT_POS_REG2, DFS_OUT_POS_REG3, DFS_OUT_POS_REG4,
      DFS_OUT_MOVES_POS, DFS_OUT_MOVES_NEG: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : dfs_out_code_ok

endpackage : dfs_pkg

// ### logic/dfs_out_sel.sv
// Purpose: level of one digital signal output from its active function code
// Assumes: status inputs already reflect the selected operating mode
// Notes: purely combinational, the top registers the result
`timescale 1ns/10ps
`default_nettype none
module dfs_out_sel (
  input wire logic [15:0] code_i,
  input wire dfs_pkg::dfs_opstate_e opstate_i,
  input wire dfs_pkg::dfs_status_s status_i,
  input wire logic user_level_i,
  output logic level_o
);
  import dfs_pkg::*;

  logic no_fault;
  logic active;

  // ----------------------------------------------------------------
  // operating state indications
  // ----------------------------------------------------------------
  assign no_fault = (opstate_i == dfs_st_ready_to_switch_on) ||
                    (opstate_i == dfs_st_switched_on) ||
                    (opstate_i == dfs_st_operation_enabled);
  assign active = (opstate_i == dfs_st_operation_enabled);

  // ----------------------------------------------------------------
  // function routing
  // ----------------------------------------------------------------
  // no error override here: a fault only shows through the chosen function
  always_comb begin
    unique case (code_i)
      DFS_OUT_FREE: level_o = user_level_i;
      DFS_OUT_NO_FAULT: level_o = no_fault;
      DFS_OUT_ACTIVE: level_o = active;
      DFS_OUT_RELMOVE_DONE: level_o = status_i.relmove_done;
      DFS_OUT_IN_POS_WIN: level_o = status_i.in_pos_win;
      DFS_OUT_IN_VEL_WIN: level_o = status_i.in_vel_win;
      DFS_OUT_VEL_BELOW: level_o = status_i.vel_below;
      DFS_OUT_CUR_BELOW: level_o = status_i.cur_below;
      DFS_OUT_HALT_ACK: level_o = status_i.halt_ack;
      DFS_OUT_STANDSTILL: level_o = status_i.standstill;
      DFS_OUT_SEL_ERROR: level_o = status_i.sel_error;
      DFS_OUT_REF_OK: level_o = status_i.ref_ok;
      DFS_OUT_SEL_WARN: level_o = status_i.sel_warning;
      DFS_OUT_POS_REG1: level_o = status_i.pos_reg[0];
      DFS_OUT_POS_REG2: level_o = status_i.pos_reg[1];
      DFS_OUT_POS_REG3: level_o = status_i.pos_reg[2];
      DFS_OUT_POS_REG4: level_o = status_i.pos_reg[3];
      DFS_OUT_MOVES_POS: level_o = status_i.moves_pos;
      DFS_OUT_MOVES_NEG: level_o = status_i.moves_neg;
      // codes are checked on write, so this arm only covers corrupt state
      default: level_o = 1'b0;
    endcase
  end

endmodule : dfs_out_sel
`default_nettype wire

// ### logic/dfs_top.sv
// Purpose: function assignment of the third digital input and two signal outputs
// Assumes: all inputs synchronous to clk_i; power_up_i marks a fresh power-on
// Notes: stored selectors model the persistent image, active ones the running set
//
// Behaviour
// - code 1 leaves input free for application; code 2 resets a fault
// - code 3 enables the power stage; code 4 requests a halt
// - code 5 starts a profile positioning movement
// - code 6 limits current; code 7 applies zero clamping
// - code 8 limits velocity to the configured value
// - codes 21, 22, 23 give reference, positive and negative limit switch
// - code 24 switches between control-loop parameter sets
// - code 28 switches off the velocity controller integral term
// - code 30 starts a relative movement after capture
// - code 31 arms the relative movement after capture
// - code 40 releases the motor holding brake
// - selector writes accepted only while power stage is disabled
// - a written selector takes effect only at the next power-up
// - outputs keep their function level on error, never forced
// - factory default: first output no fault, second output active
// - each output routes to any listed function, mode dependent
// - no-fault function asserted in ready, switched-on or enabled states
// - active function asserted only in operation enabled state
`timescale 1ns/10ps
`default_nettype none
module dfs_top (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic power_up_i,
  input wire logic factory_reset_i,
  input wire dfs_pkg::dfs_param_req_s param_req_i,
  output dfs_pkg::dfs_param_rsp_s param_rsp_o,
  input wire logic power_stage_on_i,
  input wire logic third_digital_input_i,
  input wire dfs_pkg::dfs_opstate_e opstate_i,
  input wire dfs_pkg::dfs_status_s status_i,
  input wire logic [1:0] user_out_i,
  output dfs_pkg::dfs_di_func_s di_func_o,
  output logic first_digital_output_o,
  output logic second_digital_output_o,
  output logic change_pending_o
);
  import dfs_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_b;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_b = rst_sync_q;

  // ----------------------------------------------------------------
  // parameter access decode
  // ----------------------------------------------------------------
  logic hit_in3;
  logic hit_out0;
  logic hit_out1;
  logic hit_any;
  logic wr_code_ok;
  logic wr_allowed;
  logic wr_in3;
  logic wr_out0;
  logic wr_out1;

  assign hit_in3 = (param_req_i.addr == DFS_IN3_SEL_OFS);
  assign hit_out0 = (param_req_i.addr == DFS_OUT0_SEL_OFS);
  assign hit_out1 = (param_req_i.addr == DFS_OUT1_SEL_OFS);
  assign hit_any = hit_in3 | hit_out0 | hit_out1;

  // a write is refused whole, never partly applied
  assign wr_code_ok = hit_in3 ? dfs_in_code_ok(param_req_i.wdata) :
                      dfs_out_code_ok(param_req_i.wdata);
  assign wr_allowed = param_req_i.wr && hit_any && !power_stage_on_i &&
                      wr_code_ok;
  assign wr_in3 = wr_allowed && hit_in3;
  assign wr_out0 = wr_allowed && hit_out0;
  assign wr_out1 = wr_allowed && hit_out1;

  // ----------------------------------------------------------------
  // stored selectors
  // ----------------------------------------------------------------
  // these stand for the persistent image; a factory reset or a block reset restores them
  logic [15:0] in3_stored_q;
  logic [15:0] out0_stored_q;
  logic [15:0] out1_stored_q;

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      in3_stored_q <= DFS_IN3_SEL_RST;
    end else if (ce_i) begin
      if (factory_reset_i) begin
        in3_stored_q <= DFS_IN3_SEL_RST;
      end else if (wr_in3) begin
        in3_stored_q <= param_req_i.wdata;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      out0_stored_q <= DFS_OUT0_SEL_RST;
      out1_stored_q <= DFS_OUT1_SEL_RST;
    end else if (ce_i) begin
      if (factory_reset_i) begin
        out0_stored_q <= DFS_OUT0_SEL_RST;
        out1_stored_q <= DFS_OUT1_SEL_RST;
      end else begin
        if (wr_out0) begin
          out0_stored_q <= param_req_i.wdata;
        end
        if (wr_out1) begin
          out1_stored_q <= param_req_i.wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // active selectors
  // ----------------------------------------------------------------
  // copied only at power-up so a change cannot alter wiring under a live axis
  logic [15:0] in3_active_q;
  logic [15:0] out0_active_q;
  logic [15:0] out1_active_q;

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      in3_active_q <= DFS_IN3_SEL_RST;
      out0_active_q <= DFS_OUT0_SEL_RST;
      out1_active_q <= DFS_OUT1_SEL_RST;
    end else if (ce_i && power_up_i) begin
      in3_active_q <= in3_stored_q;
      out0_active_q <= out0_stored_q;
      out1_active_q <= out1_stored_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      change_pending_o <= 1'b0;
    end else if (ce_i) begin
      if (power_up_i) begin
        // a write in the power-up cycle lands after the copy, so it stays pending
        change_pending_o <= !factory_reset_i && (wr_in3 || wr_out0 || wr_out1);
      end else begin
        change_pending_o <= (in3_stored_q != in3_active_q) ||
                            (out0_stored_q != out0_active_q) ||
                            (out1_stored_q != out1_active_q);
      end
    end
  end

  // ----------------------------------------------------------------
  // parameter response
  // ----------------------------------------------------------------
  logic [15:0] rd_value;

  always_comb begin
    rd_value = 16'h0000;
    if (hit_in3) begin
      rd_value = in3_stored_q;
    end else if (hit_out0) begin
      rd_value = out0_stored_q;
    end else if (hit_out1) begin
      rd_value = out1_stored_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      param_rsp_o <= '0;
    end else if (ce_i) begin
      param_rsp_o.ack <= param_req_i.wr | param_req_i.rd;
      if (param_req_i.wr) begin
        param_rsp_o.err <= !wr_allowed;
        param_rsp_o.rdata <= 16'h0000;
      end else if (param_req_i.rd) begin
        param_rsp_o.err <= !hit_any;
        param_rsp_o.rdata <= rd_value;
      end else begin
        param_rsp_o.err <= 1'b0;
        param_rsp_o.rdata <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // input edge detection
  // ----------------------------------------------------------------
  logic di_prev_q;
  logic di_rise;

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      di_prev_q <= 1'b0;
    end else if (ce_i) begin
      di_prev_q <= third_digital_input_i;
    end
  end

  // fault reset and start requests act on the rising edge so a held switch fires once
  assign di_rise = third_digital_input_i && !di_prev_q;

  // ----------------------------------------------------------------
  // input function: free use, fault reset, enable, halt
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      di_func_o.free_level <= 1'b0;
      di_func_o.fault_reset <= 1'b0;
    end else if (ce_i) begin
      di_func_o.free_level <= (in3_active_q == DFS_IN_FREE) &&
                              third_digital_input_i;
      di_func_o.fault_reset <= (in3_active_q == DFS_IN_FAULT_RESET) &&
                               di_rise;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      di_func_o.enable <= 1'b0;
      di_func_o.halt <= 1'b0;
    end else if (ce_i) begin
      di_func_o.enable <= (in3_active_q == DFS_IN_ENABLE) &&
                          third_digital_input_i;
      di_func_o.halt <= (in3_active_q == DFS_IN_HALT) &&
                        third_digital_input_i;
    end
  end

  // ----------------------------------------------------------------
  // input function: movement start and limitations
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      di_func_o.start_pp <= 1'b0;
    end else if (ce_i) begin
      di_func_o.start_pp <= (in3_active_q == DFS_IN_START_PP) && di_rise;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      di_func_o.cur_limit <= 1'b0;
      di_func_o.zero_clamp <= 1'b0;
      di_func_o.vel_limit <= 1'b0;
    end else if (ce_i) begin
      di_func_o.cur_limit <= (in3_active_q == DFS_IN_CUR_LIMIT) &&
                             third_digital_input_i;
      di_func_o.zero_clamp <= (in3_active_q == DFS_IN_ZERO_CLAMP) &&
                              third_digital_input_i;
      di_func_o.vel_limit <= (in3_active_q == DFS_IN_VEL_LIMIT) &&
                             third_digital_input_i;
    end
  end

  // ----------------------------------------------------------------
  // input function: switches
  // ----------------------------------------------------------------
  // switch levels pass straight through; polarity is the wiring's concern
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      di_func_o.ref_switch <= 1'b0;
      di_func_o.positive_limit_switch <= 1'b0;
      di_func_o.negative_limit_switch <= 1'b0;
    end else if (ce_i) begin
      di_func_o.ref_switch <= (in3_active_q == DFS_IN_REF_SW) &&
                              third_digital_input_i;
      di_func_o.positive_limit_switch <= (in3_active_q == DFS_IN_LIM_POS) &&
                                         third_digital_input_i;
      di_func_o.negative_limit_switch <= (in3_active_q == DFS_IN_LIM_NEG) &&
                                         third_digital_input_i;
    end
  end

  // ----------------------------------------------------------------
  // input function: controller tuning
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      di_func_o.parset_sel <= 1'b0;
      di_func_o.vel_int_off <= 1'b0;
    end else if (ce_i) begin
      di_func_o.parset_sel <= (in3_active_q == DFS_IN_PARSET) &&
                              third_digital_input_i;
      di_func_o.vel_int_off <= (in3_active_q == DFS_IN_VEL_INT_OFF) &&
                               third_digital_input_i;
    end
  end

  // ----------------------------------------------------------------
  // input function: relative movement after capture, brake
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      di_func_o.relmove_start <= 1'b0;
      di_func_o.relmove_arm <= 1'b0;
    end else if (ce_i) begin
      di_func_o.relmove_start <= (in3_active_q == DFS_IN_RELMOVE_START) &&
                                 di_rise;
      di_func_o.relmove_arm <= (in3_active_q == DFS_IN_RELMOVE_ARM) &&
                               third_digital_input_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      di_func_o.brake_release <= 1'b0;
    end else if (ce_i) begin
      di_func_o.brake_release <= (in3_active_q == DFS_IN_BRAKE_REL) &&
                                 third_digital_input_i;
    end
  end

  // ----------------------------------------------------------------
  // signal outputs
  // ----------------------------------------------------------------
  logic out0_level;
  logic out1_level;

  dfs_out_sel u_out0_sel (
    .code_i(out0_active_q),
    .opstate_i(opstate_i),
    .status_i(status_i),
    .user_level_i(user_out_i[0]),
    .level_o(out0_level)
  );

  dfs_out_sel u_out1_sel (
    .code_i(out1_active_q),
    .opstate_i(opstate_i),
    .status_i(status_i),
    .user_level_i(user_out_i[1]),
    .level_o(out1_level)
  );

  // no fault input here on purpose: an error leaves the routed level alone
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      first_digital_output_o <= 1'b0;
      second_digital_output_o <= 1'b0;
    end else if (ce_i) begin
      first_digital_output_o <= out0_level;
      second_digital_output_o <= out1_level;
    end
  end

endmodule : dfs_top
`default_nettype wire

// ### logic/dfs_top_unused_marker.sv
`timescale 1ns/10ps

// ### tb/dfs_partner.sv
// Purpose: far side of the block: the input switch and the drive state machine
// Assumes: bench commands change on the rising edge
// Notes: registers each command once, like a switch sampled by slow logic
`timescale 1ns/10ps
`default_nettype none
module dfs_partner (
  input wire logic clk_i,
  input wire logic sw_i,
  input wire dfs_pkg::dfs_opstate_e st_i,
  output logic sw_o,
  output dfs_pkg::dfs_opstate_e st_o
);
  import dfs_pkg::*;
  logic sw_q = 1'b0;
  dfs_opstate_e st_q = dfs_st_not_ready;
  assign sw_o = sw_q;
  assign st_o = st_q;
  always_ff @(posedge clk_i) begin
    sw_q <= sw_i;
    st_q <= st_i;
  end
endmodule : dfs_partner
`default_nettype wire

// ### tb/dfs_top_sva.sv
// Purpose: port level checks of the function select block
// Assumes: ce_i high whenever requests are made
// Notes: bound to dfs_top below
`timescale 1ns/10ps
`default_nettype none
module dfs_top_sva import dfs_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic power_up_i,
  input wire dfs_param_req_s param_req_i,
  input wire dfs_param_rsp_s param_rsp_o,
  input wire logic power_stage_on_i,
  input wire dfs_di_func_s di_func_o,
  input wire logic change_pending_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic req;
  logic wr;
  assign req = ce_i && (param_req_i.wr || param_req_i.rd);
  assign wr = ce_i && param_req_i.wr;
  a_ack_after_req: assert property (req |=> param_rsp_o.ack) else $error("ack missing");
  a_ack_has_cause: assert property (param_rsp_o.ack |-> $past(req)) else $error("stray ack");
  a_wr_power_on: assert property (wr && power_stage_on_i |=> param_rsp_o.err)
    else $error("write taken with power stage on");
  a_bad_code: assert property (wr && param_req_i.addr == DFS_IN3_SEL_OFS
    && param_req_i.wdata == 16'h0063 |=> param_rsp_o.err) else $error("bad code taken");
  a_good_write: assert property (wr && !power_stage_on_i && param_req_i.wdata == DFS_IN_HALT
    && param_req_i.addr == DFS_IN3_SEL_OFS |=> !param_rsp_o.err) else $error("good write refused");
  a_pend_clear: assert property (ce_i && power_up_i && !req |=> !change_pending_o)
    else $error("pending after power up");
  a_one_function: assert property ($onehot0(di_func_o)) else $error("two functions at once");
  a_start_pulse: assert property (di_func_o.start_pp && ce_i |=> !di_func_o.start_pp)
    else $error("start request held");
  c_write: cover property (wr && !power_stage_on_i);
  c_power_up: cover property (power_up_i);
  c_start: cover property (di_func_o.start_pp);
endmodule : dfs_top_sva
bind dfs_top dfs_top_sva u_sva (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .power_up_i(power_up_i), .param_req_i(param_req_i), .param_rsp_o(param_rsp_o),
  .power_stage_on_i(power_stage_on_i), .di_func_o(di_func_o),
  .change_pending_o(change_pending_o));
`default_nettype wire

// ### tb/testbench.sv
// Purpose: self-checking bench of the function select block
// Assumes: ce_i held high, one factory reset pulse near the end
// Notes: every input code is stored, powered up and exercised
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module testbench;
  import dfs_pkg::*;
  logic clk_i = 1'b0, rst_b_i = 1'b0, power_up_i = 1'b0, pwr_on = 1'b0, sw = 1'b0;
  logic tdi, q0, q1, pend;
  logic [1:0] user_out = 2'b00;
  logic fr = 1'b0;
  dfs_status_s stat = '0;
  dfs_param_req_s req = '0;
  dfs_param_rsp_s rsp;
  dfs_opstate_e st = dfs_st_not_ready, opst;
  dfs_di_func_s dif;
  int err_total = 0, tests_run = 0;
  logic [15:0] codes [16] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006,
    16'h0007, 16'h0008, 16'h0015, 16'h0016, 16'h0017, 16'h0018, 16'h001C, 16'h001E,
    16'h001F, 16'h0028};
  initial forever #12.5 clk_i = ~clk_i;
  dfs_partner u_far (.clk_i(clk_i), .sw_i(sw), .st_i(st), .sw_o(tdi), .st_o(opst));
  dfs_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .power_up_i(power_up_i),
    .factory_reset_i(fr), .param_req_i(req), .param_rsp_o(rsp),
    .power_stage_on_i(pwr_on), .third_digital_input_i(tdi), .opstate_i(opst),
    .status_i(stat), .user_out_i(user_out), .di_func_o(dif), .first_digital_output_o(q0),
    .second_digital_output_o(q1), .change_pending_o(pend));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic acc(input logic w, input logic [15:0] a, d, input logic e);
    int n;
    @(posedge clk_i) req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_i) req <= '0;
    @(negedge clk_i);
    for (n = 0; n < 4 && rsp.ack !== 1'b1; n++) @(negedge clk_i);
    `CHK(rsp.ack, 1'b1)
    `CHK(rsp.err, e)
    if (!w) `CHK(rsp.rdata, d)
  endtask : acc
  task automatic pu();
    @(posedge clk_i) power_up_i <= 1'b1;
    @(posedge clk_i) power_up_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : pu
  // one cycle for the switch, one for the block; pulse functions show only then
  task automatic inp(input logic [15:0] m, input logic p);
    @(posedge clk_i) sw <= 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    `CHK(dif, m)
    `CHK(pend, p)
    @(posedge clk_i) sw <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : inp
  task automatic so(input dfs_opstate_e s, input logic e0, e1);
    @(posedge clk_i) st <= s;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    `CHK(q0, e0)
    `CHK(q1, e1)
  endtask : so
  task automatic complete_run();
    $display("mismatches %0d of %0d checks", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    acc(1'b0, 16'h0708, 16'h0001, 1'b0);
    acc(1'b0, 16'h0712, 16'h0002, 1'b0);
    acc(1'b0, 16'h0714, 16'h0003, 1'b0);
    acc(1'b0, 16'h0700, 16'h0000, 1'b1);
    so(dfs_st_switched_on, 1'b1, 1'b0);
    so(dfs_st_operation_enabled, 1'b1, 1'b1);
    so(dfs_st_ready_to_switch_on, 1'b1, 1'b0);
    so(dfs_st_fault, 1'b0, 1'b0);
    @(posedge clk_i) pwr_on <= 1'b1;
    acc(1'b1, 16'h0708, 16'h0004, 1'b1);
    @(posedge clk_i) pwr_on <= 1'b0;
    acc(1'b1, 16'h0708, 16'h0063, 1'b1);
    acc(1'b0, 16'h0708, 16'h0001, 1'b0);
    acc(1'b1, 16'h0708, 16'h0004, 1'b0);
    for (int i = 0; i < 16; i++) begin
      acc(1'b1, 16'h0708, codes[i], 1'b0);
      inp(i == 0 ? 16'h8000 : 16'h8000 >> (i - 1), i != 0);
      pu();
      inp(16'h8000 >> i, 1'b0);
    end
    acc(1'b1, 16'h0712, 16'h0001, 1'b0);
    pu();
    @(posedge clk_i) user_out <= 2'b01;
    so(dfs_st_fault, 1'b1, 1'b0);
    acc(1'b1, 16'h0714, 16'h000D, 1'b0);
    pu();
    @(posedge clk_i) stat.standstill <= 1'b1;
    so(dfs_st_fault, 1'b1, 1'b1);
    @(posedge clk_i) fr <= 1'b1;
    @(posedge clk_i) fr <= 1'b0;
    acc(1'b0, 16'h0712, 16'h0002, 1'b0);
    acc(1'b0, 16'h0714, 16'h0003, 1'b0);
    acc(1'b0, 16'h0708, 16'h0001, 1'b0);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
